/* File: common/gpo_ctrl_pkg.sv */
// Constants shared by the general purpose output control block
package gpo_ctrl_pkg;

  // Register offsets
  localparam logic [7:0] OFS_OUT3_DELAY      = 8'h0E;
  localparam logic [7:0] OFS_OUT_CTRL_FIRST  = 8'h0F;
  localparam logic [7:0] OFS_OUT_CTRL_SECOND = 8'h10;
  localparam logic [7:0] OFS_DEVICE_CONFIG   = 8'h11;

  // Reset values
  localparam logic [7:0] RST_OUT3_DELAY      = 8'h00;
  localparam logic [7:0] RST_OUT_CTRL_FIRST  = 8'hAA;
  localparam logic [7:0] RST_OUT_CTRL_SECOND = 8'h0A;
  localparam logic [7:0] RST_DEVICE_CONFIG   = 8'h3C;

  // Delay register fields
  localparam int OFF_DLY_LSB = 4;
  localparam int ON_DLY_LSB  = 0;
  localparam int DLY_W       = 4;

  // First control register fields
  localparam int OUT2_OD_BIT   = 7;
  localparam int OUT2_GATE_LSB = 5;
  localparam int OUT2_VAL_BIT  = 4;
  localparam int OUT1_OD_BIT   = 3;
  localparam int OUT1_GATE_LSB = 1;
  localparam int OUT1_VAL_BIT  = 0;

  // Second control register fields
  localparam int OUT3_FUNC_BIT = 5;
  localparam int OUT2_FUNC_BIT = 4;
  localparam int OUT3_OD_BIT   = 3;
  localparam int OUT3_GATE_LSB = 1;
  localparam int OUT3_VAL_BIT  = 0;

  // Configuration register fields
  localparam int ON_STEP_BIT  = 7;
  localparam int OFF_STEP_BIT = 6;

  // Timing
  localparam int T_STEP_NS     = 500000;
  localparam int CLK_PERIOD_NS = 40;
  localparam int STEP_CYCLES   = T_STEP_NS / CLK_PERIOD_NS;
  localparam int STEP_MULT_L   = 1;
  localparam int STEP_MULT_H   = 2;
  localparam int MAX_CODE      = 15;

  // Enable-pin gating choices
  typedef enum logic [1:0] {
    GATE_NONE  = 2'b00,
    GATE_EN_A  = 2'b01,
    GATE_EN_B  = 2'b10,
    GATE_EN_C  = 2'b11
  } gate_type;

endpackage : gpo_ctrl_pkg

/* File: rtl/gpo_delay_and_output_control.sv */
// Output control registers, delay timer and pin drivers for three outputs
// Register map
// Four byte-wide registers sit at consecutive offsets. The first holds the
// two delay codes of the third output, off code in the upper nibble and on
// code in the lower one. The second and third hold the value, gating and
// drive type of the outputs. The fourth holds the two step selects; its
// other bits belong to neighbouring blocks and are only stored here.
//
// Access
// A write lands on the clock edge that sees the write strobe, and the new
// value steers the pins one edge later. A read is captured on the edge
// that sees the read strobe, so read data lags the strobe by one cycle.
// Read data then holds until the next read strobe. A read and a write in
// the same cycle return the old value. Offsets outside the map read zero
// and ignore writes. No wait states are inserted.
//
// Stored defaults
// A pulse on the load input copies all four stored default bytes at once.
// The load wins over a write in the same cycle, because the defaults must
// not be half overwritten while a neighbour is restoring them. Reset uses
// the fixed constants, so a load is still needed after every reset.
//
// Gating
// Each output has a two-bit field that either passes its value bit alone
// or ANDs it with one of the three enable pins. Enable pins are taken as
// already synchronous; a neighbour must resynchronise them if they are
// not, or a glitch could start the delay timer by mistake.
//
// Delay timer
// Only the third output has a timer. Its control signal is the gated value
// of that output. Each edge of the control signal picks the code for its
// direction and the step length from the matching step select, then loads
// the down counter. When the counter runs out, the delayed level follows
// the control level. Any edge while a change waits cancels it and starts
// over, so a short pulse shorter than the delay never reaches the pin.
// A zero code moves the delayed level on the very next edge.
// The step length is a parameter in clock cycles; the default gives half
// a millisecond at the nominal clock. With a different clock, the user
// must set it to match, and the counter width must hold fifteen doubled
// steps, which the check at time zero reports as an error otherwise.
//
// Pins
// Every pin has a level and an enable, both registered, so the outputs
// never glitch while the gating logic settles. Push-pull drives both
// levels. Open-drain drives low and releases the pin for a high level,
// leaving the pull-up to raise it; the line therefore rises slower than
// it falls. The second pin keeps its drive type when it carries the
// power-good signal. The third pin is released when it serves as clock
// input, and its delay timer still runs, so switching the role back to
// output shows the level that the timer has reached meanwhile.
//
// Reset
// Reset is synchronous and clears the pins to released, the read data to
// zero and the timer to level low with nothing pending. Registers take
// their documented constants at the same edge.
//
// Limitations
// There is no interrupt and no status. Reserved bits of the second control
// register are stored as written and read back, but steer nothing.
module gpo_delay_and_output_control
  import gpo_ctrl_pkg::*;
#(
  parameter int STEP_CLKS = STEP_CYCLES,   // Cycles in half a millisecond
  parameter int CNT_W     = 20             // Delay counter width
) (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // One-time memory defaults
  input  wire logic       otp_load,
  input  wire logic [7:0] otp_out3_delay,
  input  wire logic [7:0] otp_ctrl_first,
  input  wire logic [7:0] otp_ctrl_second,
  input  wire logic [7:0] otp_config,
  // Enable input pins and power-good source
  input  wire logic       enable_pin_a,
  input  wire logic       enable_pin_b,
  input  wire logic       enable_pin_c,
  input  wire logic       power_good_indicator,
  // Output pins, index 0 first output, 1 second, 2 third
  output logic      [2:0] pin_out,
  output logic      [2:0] pin_oe,
  // Pin function flags for neighbouring blocks
  output logic            out2_pin_is_output,
  output logic            out3_pin_is_output
);

  // Refuse a counter too narrow for the longest delay
  initial begin
    if (STEP_CLKS < 1 ||
        (longint'(MAX_CODE) * STEP_MULT_H * STEP_CLKS) >= (64'd1 << CNT_W))
      $error("gpo block: CNT_W too small for STEP_CLKS");
  end

  // Register state
  logic [7:0] out3_delay_ff, nxt_out3_delay;        // Delay codes
  logic [7:0] out_ctrl_first_ff, nxt_out_ctrl_first; // First control
  logic [7:0] out_ctrl_second_ff, nxt_out_ctrl_second; // Second control
  logic [7:0] device_config_ff, nxt_device_config;  // Step selects etc.
  logic [7:0] rdata_ff, nxt_rdata;                  // Read data

  // Register writes, reset constants and one-time memory loads
  always_comb begin
    nxt_out3_delay      = out3_delay_ff;
    nxt_out_ctrl_first  = out_ctrl_first_ff;
    nxt_out_ctrl_second = out_ctrl_second_ff;
    nxt_device_config   = device_config_ff;
    if (otp_load) begin
      // Stored defaults replace every field at once
      nxt_out3_delay      = otp_out3_delay;
      nxt_out_ctrl_first  = otp_ctrl_first;
      nxt_out_ctrl_second = otp_ctrl_second;
      nxt_device_config   = otp_config;
    end else if (reg_wr) begin
      // Reserved bits of the second register are kept as written
      unique case (reg_addr)
        OFS_OUT3_DELAY:      nxt_out3_delay      = reg_wdata;
        OFS_OUT_CTRL_FIRST:  nxt_out_ctrl_first  = reg_wdata;
        OFS_OUT_CTRL_SECOND: nxt_out_ctrl_second = reg_wdata;
        OFS_DEVICE_CONFIG:   nxt_device_config   = reg_wdata;
        default: ;                               // Unmapped: ignored
      endcase
    end
  end

  // Read data, captured on the read strobe; unmapped reads zero
  always_comb begin
    nxt_rdata = rdata_ff;
    if (reg_rd) begin
      unique case (reg_addr)
        OFS_OUT3_DELAY:      nxt_rdata = out3_delay_ff;
        OFS_OUT_CTRL_FIRST:  nxt_rdata = out_ctrl_first_ff;
        OFS_OUT_CTRL_SECOND: nxt_rdata = out_ctrl_second_ff;
        OFS_DEVICE_CONFIG:   nxt_rdata = device_config_ff;
        default:             nxt_rdata = 8'h00;
      endcase
    end
  end

  // Register flops
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      out3_delay_ff      <= RST_OUT3_DELAY;
      out_ctrl_first_ff  <= RST_OUT_CTRL_FIRST;
      out_ctrl_second_ff <= RST_OUT_CTRL_SECOND;
      device_config_ff   <= RST_DEVICE_CONFIG;
      rdata_ff           <= 8'h00;
    end else begin
      out3_delay_ff      <= nxt_out3_delay;
      out_ctrl_first_ff  <= nxt_out_ctrl_first;
      out_ctrl_second_ff <= nxt_out_ctrl_second;
      device_config_ff   <= nxt_device_config;
      rdata_ff           <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

  // Per-output fields gathered as arrays for the gating loop
  logic [2:0] val_bit;     // Programmed level per output
  logic [2:0] od_bit;      // Open-drain select per output
  gate_type   gate_sel [3]; // Enable-pin gating per output
  logic [2:0] gated;       // Level after enable-pin gating

  assign val_bit[0]  = out_ctrl_first_ff[OUT1_VAL_BIT];
  assign val_bit[1]  = out_ctrl_first_ff[OUT2_VAL_BIT];
  assign val_bit[2]  = out_ctrl_second_ff[OUT3_VAL_BIT];
  assign od_bit[0]   = out_ctrl_first_ff[OUT1_OD_BIT];
  assign od_bit[1]   = out_ctrl_first_ff[OUT2_OD_BIT];
  assign od_bit[2]   = out_ctrl_second_ff[OUT3_OD_BIT];
  assign gate_sel[0] =
    gate_type'(out_ctrl_first_ff[OUT1_GATE_LSB +: 2]);
  assign gate_sel[1] =
    gate_type'(out_ctrl_first_ff[OUT2_GATE_LSB +: 2]);
  assign gate_sel[2] =
    gate_type'(out_ctrl_second_ff[OUT3_GATE_LSB +: 2]);

  // Gating: value bit alone, or ANDed with the chosen enable pin
  generate
    for (genvar i = 0; i < 3; i++) begin : g_gate
      always_comb begin
        unique case (gate_sel[i])
          GATE_NONE: gated[i] = val_bit[i];
          GATE_EN_A: gated[i] = val_bit[i] & enable_pin_a;
          GATE_EN_B: gated[i] = val_bit[i] & enable_pin_b;
          GATE_EN_C: gated[i] = val_bit[i] & enable_pin_c;
        endcase
      end
    end
  endgenerate

  // Third output delay timer state
  logic             ctrl_prev_ff, nxt_ctrl_prev;  // Last control level
  logic             out3_lvl_ff, nxt_out3_lvl;    // Delayed level
  logic             pend_ff, nxt_pend;            // Change pending
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;              // Cycles left
  logic [DLY_W-1:0] code;                         // Code for this edge
  logic [CNT_W-1:0] step_len;                     // Cycles per code step

  // Pick the code and step length by the edge direction.
  // Separate step selects let on and off delays differ in range.
  always_comb begin
    if (gated[2]) begin
      code     = out3_delay_ff[ON_DLY_LSB +: DLY_W];
      step_len = device_config_ff[ON_STEP_BIT] ?
                 CNT_W'(STEP_MULT_H * STEP_CLKS) :
                 CNT_W'(STEP_MULT_L * STEP_CLKS);
    end else begin
      code     = out3_delay_ff[OFF_DLY_LSB +: DLY_W];
      step_len = device_config_ff[OFF_STEP_BIT] ?
                 CNT_W'(STEP_MULT_H * STEP_CLKS) :
                 CNT_W'(STEP_MULT_L * STEP_CLKS);
    end
  end

  // Timer next state: an edge reloads, a zero code acts at once
  always_comb begin
    nxt_ctrl_prev = gated[2];
    nxt_out3_lvl  = out3_lvl_ff;
    nxt_pend      = pend_ff;
    nxt_cnt       = cnt_ff;
    if (gated[2] != ctrl_prev_ff) begin
      // Any edge cancels whatever change was still waiting
      if (code == '0) begin
        nxt_out3_lvl = gated[2];
        nxt_pend     = 1'b0;
      end else begin
        nxt_cnt  = CNT_W'(CNT_W'(code) * step_len - 1'b1);
        nxt_pend = 1'b1;
      end
    end else if (pend_ff) begin
      if (cnt_ff == '0) begin
        nxt_out3_lvl = ctrl_prev_ff;
        nxt_pend     = 1'b0;
      end else begin
        nxt_cnt = cnt_ff - 1'b1;
      end
    end
  end

  // Timer flops
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctrl_prev_ff <= 1'b0;
      out3_lvl_ff  <= 1'b0;
      pend_ff      <= 1'b0;
      cnt_ff       <= '0;
    end else begin
      ctrl_prev_ff <= nxt_ctrl_prev;
      out3_lvl_ff  <= nxt_out3_lvl;
      pend_ff      <= nxt_pend;
      cnt_ff       <= nxt_cnt;
    end
  end

  // Pin driver state
  logic [2:0] pin_out_ff, nxt_pin_out;  // Pin output levels
  logic [2:0] pin_oe_ff, nxt_pin_oe;    // Pin output enables
  logic       f2_ff, nxt_f2;            // Second pin is an output
  logic       f3_ff, nxt_f3;            // Third pin is an output
  logic [2:0] lvl;                      // Wanted level per pin
  logic [2:0] drive;                    // Pin driven at all

  // Level and role of each pin
  always_comb begin
    nxt_f2   = out_ctrl_second_ff[OUT2_FUNC_BIT];
    nxt_f3   = out_ctrl_second_ff[OUT3_FUNC_BIT];
    lvl[0]   = gated[0];
    drive[0] = 1'b1;
    // Power-good role keeps the drive type choice of bit 7
    lvl[1]   = nxt_f2 ? gated[1] : power_good_indicator;
    drive[1] = 1'b1;
    // Clock input role releases the pin entirely
    lvl[2]   = out3_lvl_ff;
    drive[2] = nxt_f3;
  end

  // Push-pull drives both levels; open-drain only pulls low
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (!drive[i]) begin
        nxt_pin_out[i] = 1'b0;
        nxt_pin_oe[i]  = 1'b0;
      end else if (od_bit[i]) begin
        nxt_pin_out[i] = 1'b0;
        nxt_pin_oe[i]  = ~lvl[i];
      end else begin
        nxt_pin_out[i] = lvl[i];
        nxt_pin_oe[i]  = 1'b1;
      end
    end
  end

  // Pin flops; reset releases all pins, then they follow the register values one edge later
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pin_out_ff <= 3'h0;
      pin_oe_ff  <= 3'h0;
      f2_ff      <= 1'b0;
      f3_ff      <= 1'b0;
    end else begin
      pin_out_ff <= nxt_pin_out;
      pin_oe_ff  <= nxt_pin_oe;
      f2_ff      <= nxt_f2;
      f3_ff      <= nxt_f3;
    end
  end

  assign pin_out            = pin_out_ff;
  assign pin_oe             = pin_oe_ff;
  assign out2_pin_is_output = f2_ff;
  assign out3_pin_is_output = f3_ff;

endmodule : gpo_delay_and_output_control

/* File: bench/gpo_load_model.sv */
// Far-side model: enable pin drivers and the loads on the outputs
module gpo_load_model (
  // Commanded enable levels
  input  wire logic [2:0] en_cmd,
  output logic            enable_pin_a,
  output logic            enable_pin_b,
  output logic            enable_pin_c,
  // Output pins and resolved wire levels
  input  wire logic [2:0] pin_out,
  input  wire logic [2:0] pin_oe,
  output logic      [2:0] pin_wire
);
  timeunit 1ns;
  timeprecision 1ps;
  // Enable pins are plain levels from the bench
  assign {enable_pin_c, enable_pin_b, enable_pin_a} = en_cmd;
  // Released pins sit at the external pull-up
  assign pin_wire = (pin_oe & pin_out) | ~pin_oe;
endmodule : gpo_load_model

/* File: bench/gpo_ctrl_chk.sv */
// Assertion checker for the output control block
module gpo_ctrl_chk
  import gpo_ctrl_pkg::*;
(
  // Clock, reset and register port
  input wire logic       clk_sys,
  input wire logic       sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       otp_load,
  input wire logic [7:0] otp_ctrl_first,
  input wire logic [7:0] otp_ctrl_second,
  // Pins
  input wire logic       enable_pin_a,
  input wire logic       enable_pin_b,
  input wire logic       enable_pin_c,
  input wire logic       power_good_indicator,
  input wire logic [2:0] pin_out,
  input wire logic [2:0] pin_oe,
  input wire logic       out2_pin_is_output,
  input wire logic       out3_pin_is_output
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] c1_ff, c2_ff, nxt_c1, nxt_c2; // Shadow control registers
  logic       wr_ok;                        // Load beats a write
  logic [3:0] en4;                          // Gate source per code
  logic       lvl0, lvl1;                   // Gated levels
  logic [1:0] exp0, exp1;                   // Expected oe and out
  assign wr_ok = reg_wr && !otp_load;
  // Shadow copy follows loads and writes
  always_comb begin
    nxt_c1 = otp_load ? otp_ctrl_first : c1_ff;
    nxt_c2 = otp_load ? otp_ctrl_second : c2_ff;
    if (wr_ok && reg_addr == OFS_OUT_CTRL_FIRST) nxt_c1 = reg_wdata;
    if (wr_ok && reg_addr == OFS_OUT_CTRL_SECOND) nxt_c2 = reg_wdata;
  end
  always_ff @(posedge clk_sys) begin
    c1_ff <= sys_rst ? RST_OUT_CTRL_FIRST : nxt_c1;
    c2_ff <= sys_rst ? RST_OUT_CTRL_SECOND : nxt_c2;
  end
  assign en4 = {enable_pin_c, enable_pin_b, enable_pin_a, 1'b1};
  assign lvl0 = c1_ff[0] & en4[c1_ff[2:1]];
  assign lvl1 = c2_ff[4] ? c1_ff[4] & en4[c1_ff[6:5]] : power_good_indicator;
  // Open drain only pulls low, so a high level releases the pin
  assign exp0 = c1_ff[3] ? {~lvl0, 1'b0} : {1'b1, lvl0};
  assign exp1 = c1_ff[7] ? {~lvl1, 1'b0} : {1'b1, lvl1};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence s_rd_first;
    reg_rd && reg_addr == OFS_OUT_CTRL_FIRST;
  endsequence
  a_out1_pin: assert property (
    1'b1 |=> {pin_oe[0], pin_out[0]} == $past(exp0))
    else $error("first pin drive wrong");
  a_out2_pin: assert property (
    1'b1 |=> {pin_oe[1], pin_out[1]} == $past(exp1))
    else $error("second pin drive wrong");
  a_reset_quiet: assert property (disable iff (1'b0)
    sys_rst |=> pin_oe == 3'h0 && pin_out == 3'h0 && reg_rdata == 8'h00)
    else $error("outputs not cleared by reset");
  a_rd_first: assert property (
    s_rd_first |=> reg_rdata == $past(c1_ff))
    else $error("first control read wrong");
  a_rd_unmapped: assert property (reg_rd && (reg_addr < OFS_OUT3_DELAY
    || reg_addr > OFS_DEVICE_CONFIG) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_rd_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_pin_func: assert property (
    1'b1 |=> {out3_pin_is_output, out2_pin_is_output} == $past(c2_ff[5:4]))
    else $error("pin function flags wrong");
  a_clk_role: assert property (
    !c2_ff[5] |=> pin_oe[2] == 1'b0 && pin_out[2] == 1'b0)
    else $error("third pin driven in clock role");
  a_out3_od: assert property (
    c2_ff[5] && c2_ff[3] |=> pin_out[2] == 1'b0)
    else $error("open-drain third pin drove high");
endmodule : gpo_ctrl_chk
bind gpo_delay_and_output_control gpo_ctrl_chk u_gpo_ctrl_chk (.*);

/* File: bench/tb_top.sv */
// Self-checking testbench for the output control block
module tb_top
  import gpo_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int S = 8; // Short half-millisecond step for simulation
  typedef struct {int t0; int n;} note_type;
  logic       clk_sys, sys_rst, reg_wr, reg_rd, otp_load, rise;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, v, r;
  logic [7:0] otp_out3_delay, otp_ctrl_first, otp_ctrl_second, otp_config;
  logic       enable_pin_a, enable_pin_b, enable_pin_c, power_good_indicator;
  logic [2:0] pin_out, pin_oe, pin_wire, en_cmd;
  logic       out2_pin_is_output, out3_pin_is_output;
  logic       rd_seen = 1'b0, p2_prev = 1'b0;
  logic [31:0] seed = 32'h0000_0044; // Xorshift state
  note_type   dly_q[$], nt;           // Expected third-pin changes
  logic [7:0] rd_q[$];                // Expected read data
  int         miscompares = 0, cmp_count = 0, cyc = 0, n;
  logic [7:0] ofs [4] = '{OFS_OUT3_DELAY, OFS_OUT_CTRL_FIRST,
                          OFS_OUT_CTRL_SECOND, OFS_DEVICE_CONFIG};
  logic [7:0] cfg_t [8] = '{8'h00, 8'h00, 8'h80, 8'h80,
                            8'h40, 8'h40, 8'hC0, 8'hC0};
  logic [7:0] dly_t [8] = '{8'h01, 8'hF0, 8'h03, 8'h50,
                            8'h0F, 8'h20, 8'h0F, 8'hF0};
  gpo_delay_and_output_control #(.STEP_CLKS(S))
    u_gpo_delay_and_output_control (.*);
  gpo_load_model u_gpo_load_model (.*);
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd
  task automatic idle(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask : idle
  // One register access; a read notes its expected data
  task automatic bus(input logic w, input logic [7:0] a, d);
    if (!w) rd_q.push_back(d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = !w;
    idle(1);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    idle(1);
  endtask : bus
  task automatic note(input int k);
    dly_q.push_back('{cyc, k});
  endtask : note
  task automatic chk8(input logic [7:0] g, e);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %0t read %h exp %h", $time, g, e);
    end
  endtask : chk8
  // Pin path depth is a design latency; the step count is what matters
  task automatic chk_dly(input int d, k);
    cmp_count++;
    if (d < k + 2 || d > k + 6) begin
      miscompares++;
      $display("MISMATCH %0t delay %0d exp %0d", $time, d, k);
    end
  endtask : chk_dly
  task automatic print_verdict();
    miscompares += dly_q.size();
    $display("Compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict
  // Watcher: read data and third-pin changes against the notes
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (rd_seen) chk8(reg_rdata, rd_q.pop_front());
    rd_seen = reg_rd;
    if (!sys_rst && pin_out[2] !== p2_prev) begin
      nt = dly_q.size() > 0 ? dly_q.pop_front() : note_type'{0, -99};
      chk_dly(cyc - nt.t0, nt.n);
    end
    p2_prev = pin_out[2];
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    print_verdict();
  end
  initial begin
    {reg_wr, reg_rd, otp_load, power_good_indicator} = 4'h0;
    {reg_addr, reg_wdata, en_cmd} = 19'h0;
    {otp_out3_delay, otp_ctrl_first, otp_ctrl_second, otp_config} = 32'h0;
    sys_rst = 1'b1;
    idle(4);
    sys_rst = 1'b0;
    bus(0, 8'h12, 8'h00); // Unmapped offset reads zero
    bus(0, OFS_OUT_CTRL_FIRST, RST_OUT_CTRL_FIRST);
    otp_out3_delay = rnd();
    otp_ctrl_first = rnd();
    otp_ctrl_second = rnd() & 8'hFE;
    otp_config = rnd();
    otp_load = 1'b1;
    idle(1);
    otp_load = 1'b0;
    bus(0, ofs[0], otp_out3_delay);
    bus(0, ofs[1], otp_ctrl_first);
    bus(0, ofs[2], otp_ctrl_second);
    bus(0, ofs[3], otp_config);
    bus(1, OFS_DEVICE_CONFIG, 8'h00);
    bus(1, OFS_OUT3_DELAY, 8'h00);
    bus(1, OFS_OUT_CTRL_SECOND, 8'h20);
    for (int g = 0; g < 4; g++) begin
      if (g == 0) note(0);
      bus(1, OFS_OUT_CTRL_SECOND, 8'h21 | {5'h00, g[1:0], 1'b0});
      if (g > 0) note(0);
      if (g > 0) en_cmd = 3'(1 << (g - 1));
      idle(8);
      note(0);
      bus(1, OFS_OUT_CTRL_SECOND, 8'h20);
      en_cmd = 3'h0;
      idle(8);
    end
    foreach (cfg_t[i]) begin
      rise = (i % 2 == 0);
      n = rise ? dly_t[i][3:0] : dly_t[i][7:4];
      n = n * S * (cfg_t[i][rise ? 7 : 6] ? 2 : 1);
      bus(1, OFS_DEVICE_CONFIG, cfg_t[i]);
      bus(1, OFS_OUT3_DELAY, dly_t[i]);
      note(n);
      bus(1, OFS_OUT_CTRL_SECOND, {7'h10, rise});
      idle(n + 10);
    end
    // A fall before the on-delay expires must cancel the rise
    bus(1, OFS_OUT3_DELAY, 8'h0F);
    bus(1, OFS_OUT_CTRL_SECOND, 8'h21);
    idle(20);
    bus(1, OFS_OUT_CTRL_SECOND, 8'h20);
    idle(300);
    repeat (40) begin
      v = rnd();
      r = rnd();
      en_cmd = r[2:0];
      power_good_indicator = r[3];
      bus(1, OFS_OUT_CTRL_FIRST, v);
      bus(1, OFS_OUT_CTRL_SECOND, 8'h20 | (rnd() & 8'hD8));
      bus(0, OFS_OUT_CTRL_FIRST, v);
    end
    sys_rst = 1'b1;
    idle(4);
    sys_rst = 1'b0;
    bus(0, OFS_OUT_CTRL_SECOND, RST_OUT_CTRL_SECOND);
    bus(0, OFS_OUT_CTRL_FIRST, RST_OUT_CTRL_FIRST);
    idle(4);
    print_verdict();
  end
endmodule : tb_top
